// [pkg/scp_consts.svh]
// Constants of the scan chain and test port control block.
// Assumes inclusion by bare name from the package and the design.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ------------------------------------------------------------------
// Chain geometry
// ------------------------------------------------------------------
`define SCP_PINS        21
`define SCP_CHAIN       63
`define SCP_CELLS       3
`define SCP_OFS_DATA    2
`define SCP_OFS_CTRL    1
`define SCP_OFS_PULL    0
`define SCP_NSYNC       28

// ------------------------------------------------------------------
// Register indices, byte address is four times the index
// ------------------------------------------------------------------
`define SCP_ADR_MSB     9
`define SCP_ADR_LSB     2
`define SCP_IDX_CTRL    8'h35
`define SCP_IDX_STAT    8'h34
`define SCP_IDX_IRQ     8'h36
`define SCP_IDX_MASK    8'h37

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define SCP_BIT_TPD     7
`define SCP_BIT_TRF     4
`define SCP_CTRL_RWMSK  8'h13
`define SCP_CTRL_RST    8'h00
`define SCP_STAT_RST    8'h00
`define SCP_IRQ_RST     3'h0
`define SCP_NIRQ        3
`define SCP_IRQ_TPD     0
`define SCP_IRQ_TRF     1
`define SCP_IRQ_UPD     2
`define SCP_WIN_NS      20
`define SCP_CLK_NS      5
`define SCP_WIN_CYC     (`SCP_WIN_NS / `SCP_CLK_NS)
`define SCP_WIN_W       3

`endif

// [pkg/scp_pkg.sv]
// Types shared by the scan chain and test port control block.
// Assumes the constants header is on the include path.
`include "scp_consts.svh"

package scp_pkg;

    // One bit per port pin for each kind of boundary cell.
    typedef struct packed {
        logic [`SCP_PINS-1:0] data;
        logic [`SCP_PINS-1:0] dir;
        logic [`SCP_PINS-1:0] pull;
    } scp_port_type;

    typedef logic [`SCP_CHAIN-1:0] scp_chain_type;

endpackage

// [src/scp_top.sv]
// Boundary-scan chain low end plus test port control and status registers.
// Assumes an external tap controller supplies capture, shift, update and
// reset-register levels that change with the test clock; a classic
// Wishbone master reaches the registers.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "scp_consts.svh"

module scp_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [9:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      irq_o,
    input  wire logic                 tck_i,
    input  wire logic                 tdi_i,
    output logic                      tdo_o,
    output logic                      tdo_oe_o,
    input  wire logic                 scan_capture_i,
    input  wire logic                 scan_shift_i,
    input  wire logic                 scan_update_i,
    input  wire logic                 scan_extest_i,
    input  wire logic                 scan_reset_instruction_i,
    input  wire logic                 test_port_fuse_enable_i,
    input  wire logic [20:0]          pin_in_i,
    input  wire scp_pkg::scp_port_type core_i,
    output scp_pkg::scp_port_type     pin_o,
    output logic                      test_port_enable_o,
    output logic [7:0]                mcu_general_control_o
);
    import scp_pkg::*;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic [`SCP_NSYNC-1:0] sync1_q;
    logic [`SCP_NSYNC-1:0] sync2_q;
    logic                  tck_d1_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q  <= '0;
            sync2_q  <= '0;
            tck_d1_q <= 1'b0;
        end else begin
            sync1_q  <= {pin_in_i, tck_i, tdi_i, scan_capture_i,
                         scan_shift_i, scan_update_i, scan_extest_i,
                         scan_reset_instruction_i};
            sync2_q  <= sync1_q;
            tck_d1_q <= sync2_q[6];
        end
    end

    logic [`SCP_PINS-1:0] pin_s;
    logic                 tck_s;
    logic                 tdi_s;
    logic                 cap_s;
    logic                 shf_s;
    logic                 upd_s;
    logic                 ext_s;
    logic                 rsti_s;
    logic                 tck_rise;
    logic                 tck_fall;

    assign pin_s    = sync2_q[`SCP_NSYNC-1:7];
    assign tck_s    = sync2_q[6];
    assign tdi_s    = sync2_q[5];
    assign cap_s    = sync2_q[4];
    assign shf_s    = sync2_q[3];
    assign upd_s    = sync2_q[2];
    assign ext_s    = sync2_q[1];
    assign rsti_s   = sync2_q[0];
    assign tck_rise = tck_s & ~tck_d1_q;
    assign tck_fall = ~tck_s & tck_d1_q;

    // The fuse is a strap: it is caught after reset release, never by
    // the reset itself, and resampled each cycle through two stages.
    logic fuse1_q;
    logic fuse2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse1_q <= 1'b0;
            fuse2_q <= 1'b0;
        end else begin
            fuse1_q <= test_port_fuse_enable_i;
            fuse2_q <= fuse1_q;
        end
    end

    // --------------------------------------------------------------
    // Registers and the port enable
    // --------------------------------------------------------------
    logic [7:0]               ctrl_q;
    logic                     trf_q;
    logic [`SCP_NIRQ-1:0]     ist_q;
    logic [`SCP_NIRQ-1:0]     imask_q;
    logic                     port_en_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_en_q <= 1'b0;
        end else begin
            port_en_q <= fuse2_q & ~ctrl_q[`SCP_BIT_TPD];
        end
    end

    // --------------------------------------------------------------
    // Boundary-scan chain
    // --------------------------------------------------------------
    scp_chain_type chain_q;
    scp_chain_type cap_val;
    scp_port_type  upd_q;
    logic          upd_done;

    genvar g;
    generate
        for (g = 0; g < `SCP_PINS; g = g + 1) begin : g_cell
            assign cap_val[`SCP_CELLS*g+`SCP_OFS_DATA] = pin_s[g];
            assign cap_val[`SCP_CELLS*g+`SCP_OFS_CTRL] = core_i.dir[g];
            assign cap_val[`SCP_CELLS*g+`SCP_OFS_PULL] = core_i.pull[g];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    upd_q.data[g] <= 1'b0;
                    upd_q.dir[g]  <= 1'b0;
                    upd_q.pull[g] <= 1'b0;
                end else if (port_en_q && tck_fall && upd_s) begin
                    upd_q.data[g] <= chain_q[`SCP_CELLS*g+`SCP_OFS_DATA];
                    upd_q.dir[g]  <= chain_q[`SCP_CELLS*g+`SCP_OFS_CTRL];
                    upd_q.pull[g] <= chain_q[`SCP_CELLS*g+`SCP_OFS_PULL];
                end
            end
        end
    endgenerate

    assign upd_done = port_en_q & tck_fall & upd_s;

    // Capture and shift on the rising test clock edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chain_q <= '0;
        end else if (port_en_q && tck_rise) begin
            if (cap_s) begin
                chain_q <= cap_val;
            end else if (shf_s) begin
                chain_q <= {tdi_s, chain_q[`SCP_CHAIN-1:1]};
            end
        end
    end

    // Test data out changes on the falling edge, as the standard asks.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            if (tck_fall) begin
                tdo_o <= chain_q[0];
            end
            if (!port_en_q) begin
                tdo_oe_o <= 1'b0;
            end else if (tck_fall) begin
                tdo_oe_o <= shf_s;
            end
        end
    end

    // Pins follow the update cells in external test with the port enabled, else the core.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= '0;
        end else if (ext_s && port_en_q) begin
            pin_o <= upd_q;
        end else begin
            pin_o <= core_i;
        end
    end

    // --------------------------------------------------------------
    // Wishbone slave
    // --------------------------------------------------------------
    logic       req;
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] rdata;

    assign req = wb_cyc_i & wb_stb_i;
    assign acc = req & wb_ack_o;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign rd  = acc & ~wb_we_i;
    assign idx = wb_adr_i[`SCP_ADR_MSB:`SCP_ADR_LSB];

    // Unmapped indices answer with zero and ignore writes.
    always_comb begin
        rdata = 8'h00;
        case (idx)
            `SCP_IDX_CTRL: rdata = ctrl_q;
            `SCP_IDX_STAT: rdata[`SCP_BIT_TRF] = trf_q;
            `SCP_IDX_IRQ:  rdata[`SCP_NIRQ-1:0] = ist_q;
            `SCP_IDX_MASK: rdata[`SCP_NIRQ-1:0] = imask_q;
            default:       rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= {24'h000000, rdata};
        end
    end

    // --------------------------------------------------------------
    // Timed write of the disable bit
    // --------------------------------------------------------------
    logic                  wr_ctrl;
    logic                  wr_val;
    logic                  pend_q;
    logic [`SCP_WIN_W-1:0] win_q;
    logic                  tpd_commit;

    assign wr_ctrl    = wr & (idx == `SCP_IDX_CTRL);
    assign wr_val     = wb_dat_i[`SCP_BIT_TPD];
    assign tpd_commit = wr_ctrl & (win_q != '0) & (pend_q == wr_val);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_q  <= '0;
            pend_q <= 1'b0;
        end else if (wr_ctrl && !tpd_commit) begin
            win_q  <= `SCP_WIN_W'(`SCP_WIN_CYC);
            pend_q <= wr_val;
        end else if (tpd_commit) begin
            win_q  <= '0;
        end else if (win_q != '0) begin
            win_q  <= win_q - `SCP_WIN_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SCP_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (ctrl_q & ~`SCP_CTRL_RWMSK)
                        | (wb_dat_i[7:0] & `SCP_CTRL_RWMSK);
            end
            if (tpd_commit) begin
                ctrl_q[`SCP_BIT_TPD] <= wr_val;
            end
        end
    end

    // --------------------------------------------------------------
    // Reset source flag
    // --------------------------------------------------------------
    logic trf_set;

    assign trf_set = rsti_s & fuse2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trf_q <= 1'b0;
        end else if (trf_set) begin
            trf_q <= 1'b1;
        end else if (wr && idx == `SCP_IDX_STAT
                     && !wb_dat_i[`SCP_BIT_TRF]) begin
            trf_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Interrupts
    // --------------------------------------------------------------
    logic [`SCP_NIRQ-1:0] ev;

    assign ev[`SCP_IRQ_TPD] = tpd_commit;
    assign ev[`SCP_IRQ_TRF] = trf_set & ~trf_q;
    assign ev[`SCP_IRQ_UPD] = upd_done;

    // The clearing read drops only the bits that it returned, so an event
    // that lands while the read is in flight is not lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q <= `SCP_IRQ_RST;
        end else if (rd && idx == `SCP_IDX_IRQ) begin
            ist_q <= (ist_q & ~wb_dat_o[`SCP_NIRQ-1:0]) | ev;
        end else begin
            ist_q <= ist_q | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imask_q <= `SCP_IRQ_RST;
        end else if (wr && idx == `SCP_IDX_MASK) begin
            imask_q <= wb_dat_i[`SCP_NIRQ-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o                 <= 1'b0;
            test_port_enable_o    <= 1'b0;
            mcu_general_control_o <= `SCP_CTRL_RST;
        end else begin
            irq_o                 <= |(ist_q & imask_q);
            test_port_enable_o    <= port_en_q;
            mcu_general_control_o <= ctrl_q;
        end
    end

endmodule

// [tb/scp_tester.sv]
// Model of the boundary-scan tester driving the test clock and levels.
// Assumes the bench calls frame with the block out of reset.
`timescale 1ns/10ps
module scp_tester (
    output logic      tck_o,
    output logic      tdi_o,
    output logic      cap_o,
    output logic      shf_o,
    output logic      upd_o,
    input  wire logic tdo_i
);
    // ---------------------------------------------------------------
    // Frame sequencing
    // ---------------------------------------------------------------
    initial begin
        {tck_o, tdi_o, cap_o, shf_o, upd_o} = 5'h00;
    end
    // The test clock stands low outside frames. Levels change in the middle
    // of a clock phase so that they never race a test clock edge.
    task automatic frame(input logic [62:0] v, output logic [62:0] got);
        #1.3 cap_o = 1'b1;
        #80 tck_o = 1'b1;
        #40 cap_o = 1'b0;
        shf_o = 1'b1;
        #40 tck_o = 1'b0;
        for (int i = 0; i < 63; i++) begin
            #40 got[i] = tdo_i;
            tdi_o = v[i];
            #40 tck_o = 1'b1;
            #40 shf_o = (i != 62);
            #40 tck_o = 1'b0;
        end
        #40 upd_o = 1'b1;
        tdi_o = ~tdi_o;
        #40 tck_o = 1'b1;
        #80 tck_o = 1'b0;
        #40 upd_o = 1'b0;
    endtask
endmodule

// [tb/scp_top_asserts.sv]
// Checker for the bus, control and pin outputs of the scan block.
// Assumes it is bound to scp_top and sees only that module's ports.
`timescale 1ns/10ps
module scp_top_asserts
    import scp_pkg::*;
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic [9:0]   wb_adr_i,
    input wire logic         wb_we_i,
    input wire logic         wb_cyc_i,
    input wire logic [31:0]  wb_dat_o,
    input wire logic         wb_ack_o,
    input wire logic         irq_o,
    input wire logic         tdo_oe_o,
    input wire logic         scan_extest_i,
    input wire scp_port_type core_i,
    input wire scp_port_type pin_o,
    input wire logic         test_port_enable_o,
    input wire logic [7:0]   mcu_general_control_o
);
    // ---------------------------------------------------------------
    // Helpers and properties
    // ---------------------------------------------------------------
    logic [7:0] idx;
    logic       weff;
    logic [7:0] gap_q;
    assign idx  = wb_adr_i[9:2];
    assign weff = wb_cyc_i && wb_we_i && wb_ack_o && idx == 8'h35;
    // Cycles since the last control write; saturates so it never wraps.
    always_ff @(posedge clk_i) begin
        if (rst_i || weff) begin
            gap_q <= 8'h00;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property ($rose(wb_cyc_i) |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (
        wb_ack_o && !wb_we_i && (idx < 8'h34 || idx > 8'h37)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (
        wb_ack_o && !wb_we_i && idx == 8'h35
        |-> wb_dat_o[7:0] == mcu_general_control_o)
        else $error("control read differs from control output");
    a_disable_pair: assert property (
        $changed(mcu_general_control_o[7]) |-> $past(weff) || $past(weff, 2))
        else $error("disable bit changed without a write");
    a_single_write: assert property (
        weff && gap_q > 8'h04 |=> $stable(mcu_general_control_o[7]) [*2])
        else $error("lone write changed the disable bit");
    a_disable_blocks: assert property (
        mcu_general_control_o[7] [*3] |-> !test_port_enable_o)
        else $error("port enabled while disable bit set");
    a_oe_disabled: assert property (
        !test_port_enable_o [*8] |-> !tdo_oe_o)
        else $error("tdo driven while port disabled");
    a_pins_core: assert property (
        !$past(rst_i)
        && (!test_port_enable_o || !$past(scan_extest_i, 3))
        |-> pin_o == $past(core_i))
        else $error("pins left core values without boundary test");
    c_commit: cover property (weff && gap_q < 8'h04);
    c_irq: cover property ($rose(irq_o));
    c_update: cover property ($changed(pin_o) && scan_extest_i);
endmodule

bind scp_top scp_top_asserts u_asserts (.clk_i, .rst_i, .wb_adr_i,
    .wb_we_i, .wb_cyc_i, .wb_dat_o, .wb_ack_o, .irq_o, .tdo_oe_o,
    .scan_extest_i, .core_i, .pin_o, .test_port_enable_o,
    .mcu_general_control_o);

// [tb/scp_top_tb_top.sv]
// Self-checking bench for the scan chain and test port control block.
// Assumes the design package and the tester model are compiled first.
`timescale 1ns/10ps
module scp_top_tb_top;
    import scp_pkg::*;
    logic         clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic         irq_o, tck_i, tdi_i, tdo_o, tdo_oe_o, scan_capture_i;
    logic         scan_shift_i, scan_update_i, scan_extest_i;
    logic         scan_reset_instruction_i, test_port_fuse_enable_i;
    logic         test_port_enable_o;
    logic [9:0]   wb_adr_i;
    logic [31:0]  wb_dat_i, wb_dat_o;
    logic [3:0]   wb_sel_i;
    logic [7:0]   mcu_general_control_o;
    logic [20:0]  pin_in_i, ed, ec, ep, gd;
    logic [62:0]  got;
    scp_port_type core_i, pin_o;
    int           failures, num_checks;
    localparam logic [62:0] vec = 63'h1234_5678_9ABC_DEF0;
    localparam logic [23:0] rows [5] = '{24'h35FF13, 24'h350000,
        24'h370505, 24'h34FF00, 24'h10FF00};

    scp_top u_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .irq_o,
        .tck_i, .tdi_i, .tdo_o, .tdo_oe_o, .scan_capture_i, .scan_shift_i,
        .scan_update_i, .scan_extest_i, .scan_reset_instruction_i,
        .test_port_fuse_enable_i, .pin_in_i, .core_i, .pin_o,
        .test_port_enable_o, .mcu_general_control_o);
    scp_tester u_t (.tck_o(tck_i), .tdi_o(tdi_i), .cap_o(scan_capture_i),
        .shf_o(scan_shift_i), .upd_o(scan_update_i), .tdo_i(tdo_o));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [62:0] g, input logic [62:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_adr_i <= {a, 2'h0};
        wb_we_i  <= w;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk(q, {24'h0, e});
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        failures++;
        stop_test();
    end
    initial begin
        {wb_we_i, wb_cyc_i, wb_stb_i, scan_extest_i} = 4'h0;
        scan_reset_instruction_i = 1'b0;
        test_port_fuse_enable_i = 1'b1;
        {wb_adr_i, wb_dat_i, wb_sel_i} = {42'h0, 4'hF};
        pin_in_i = 21'h15A5A3;
        core_i = 63'h5A5A_0F0F_3C3C_1234;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(test_port_enable_o, 1'b1);
        rd(8'h35, 8'h00);
        rd(8'h34, 8'h00);
        chk(pin_o, core_i);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        wr(8'h35, 8'h80);
        wr(8'h35, 8'h80);
        rd(8'h35, 8'h80);
        repeat (4) @(posedge clk_i);
        chk({test_port_enable_o, irq_o}, 2'h1);
        chk(mcu_general_control_o, 8'h80);
        rd(8'h36, 8'h01);
        rd(8'h36, 8'h00);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        scan_extest_i <= 1'b1;
        u_t.frame(~vec, got);
        repeat (4) @(posedge clk_i);
        chk(pin_o, core_i);
        wr(8'h35, 8'h00);
        repeat (3) @(posedge clk_i);
        wr(8'h35, 8'h00);
        rd(8'h35, 8'h80);
        wr(8'h35, 8'h00);
        wr(8'h35, 8'h00);
        rd(8'h35, 8'h00);
        repeat (6) @(posedge clk_i);
        u_t.frame(vec, got);
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < 21; k++) begin
            {ed[k], ec[k], ep[k]} = vec[3*k +: 3];
            gd[k] = got[3*k+2];
        end
        chk(pin_o, {ed, ec, ep});
        chk(gd, pin_in_i);
        rd(8'h36, 8'h05);
        scan_reset_instruction_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        scan_reset_instruction_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(8'h34, 8'h10);
        wr(8'h34, 8'h10);
        rd(8'h34, 8'h10);
        wr(8'h34, 8'h00);
        rd(8'h34, 8'h00);
        scan_reset_instruction_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        scan_reset_instruction_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(8'h34, 8'h10);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h34, 8'h00);
        chk(test_port_enable_o, 1'b1);
        test_port_fuse_enable_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk(test_port_enable_o, 1'b0);
        stop_test();
    end
endmodule
